// ==== shared/dtd_regs.svh ====
/*
 * constants of the tone-pair receiver: tone frequencies, host register
 * select values, status and control bit positions, settling time.
 * assumes inclusion by bare name from the design files.
 */
`ifndef DTD_REGS_SVH
`define DTD_REGS_SVH

`define DTD_CLK_HZ 125000000
`define DTD_F_LOW0 697
`define DTD_F_LOW1 770
`define DTD_F_LOW2 852
`define DTD_F_LOW3 941
`define DTD_F_HIGH0 1209
`define DTD_F_HIGH1 1336
`define DTD_F_HIGH2 1477
`define DTD_F_HIGH3 1633
`define DTD_AVG_PERIODS 4
`define DTD_TOL_PERMILLE 20
`define DTD_SEL_DATA 1'b0
`define DTD_SEL_STATUS 1'b1
`define DTD_STAT_IRQ_BIT 0
`define DTD_STAT_RXV_BIT 2
`define DTD_CTRL_IRQEN_BIT 0
`define DTD_CTRL_CPM_BIT 1
`define DTD_SETTLE_NS 100
`define DTD_CLK_PERIOD_NS 8
`define DTD_SETTLE_CYC ((`DTD_SETTLE_NS + `DTD_CLK_PERIOD_NS - 1) / `DTD_CLK_PERIOD_NS)

`endif

// ==== shared/dtd_pkg.sv ====
/*
 * types of the tone-pair receiver: steering states and state records.
 * assumes dtd_regs.svh on the include path.
 */
`default_nettype none
package dtd_pkg;
    typedef enum logic [1:0] {
        DTD_ST_IDLE = 2'b00,
        DTD_ST_SETTLE = 2'b01,
        DTD_ST_HELD = 2'b10
    } dtd_steer_type;

    typedef struct packed {
        logic tone_s1;
        logic tone_s2;
        logic tone_d;
        logic [23:0] cnt;
        logic [3:0] nper;
        logic valid;
        logic [1:0] idx;
        logic prev_ok;
        logic [1:0] prev_idx;
    } dtd_meas_type;

    typedef struct packed {
        logic [1:0] steer_sy;
        logic [1:0] cp_sy;
        logic [1:0] cs_sy;
        logic [1:0] rd_sy;
        logic [1:0] wr_sy;
        logic [1:0] rs_sy;
        logic [7:0] din_sy;
        logic steer_d;
        logic rd_d;
        logic wr_d;
        dtd_steer_type st;
        logic [3:0] settle;
        logic [3:0] code;
        logic [3:0] rx_code;
        logic delayed_steer;
        logic rx_valid;
        logic irq_pend;
        logic irq_en;
        logic cp_mode;
        logic stat_read;
        logic early_steer;
        logic guard;
        logic guard_oe;
        logic irq_oe;
        logic irq_lvl;
        logic [3:0] dout;
        logic dout_oe;
    } dtd_top_type;
endpackage : dtd_pkg
`default_nettype wire

// ==== src/dtd_tone_meas.sv ====
/*
 * period measurement of one limited tone group over several periods,
 * classified against four nominal frequencies.
 * assumes a full-rail comparator output, asynchronous to core_clk.
 */
`include "dtd_regs.svh"
`default_nettype none
module dtd_tone_meas
    import dtd_pkg::*;
#(
    parameter int CLK_HZ = `DTD_CLK_HZ,
    parameter int AVG_N = `DTD_AVG_PERIODS,
    parameter int TOL_PM = `DTD_TOL_PERMILLE,
    parameter int F0 = `DTD_F_LOW0,
    parameter int F1 = `DTD_F_LOW1,
    parameter int F2 = `DTD_F_LOW2,
    parameter int F3 = `DTD_F_LOW3
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic tone_in,
    output logic tone_valid,
    output logic [1:0] tone_idx
);
    function automatic logic [23:0] bound(int f, int pm);
        longint v;
        v = longint'(CLK_HZ) * AVG_N * pm / (longint'(f) * 1000);
        return v[23:0];
    endfunction : bound

    localparam int FR [4] = '{F0, F1, F2, F3};
    localparam logic [3:0] LAST = 4'(AVG_N - 1);

    dtd_meas_type s_r, s_nxt;
    logic rise;
    logic m_ok;
    logic [1:0] m_idx;

    always_comb begin
        s_nxt = s_r;
        m_ok = 1'b0;
        m_idx = 2'b00;
        s_nxt.tone_s1 = tone_in;
        s_nxt.tone_s2 = s_r.tone_s1;
        s_nxt.tone_d = s_r.tone_s2;
        rise = s_r.tone_s2 & ~s_r.tone_d;
        s_nxt.cnt = s_r.cnt + 24'h000001;
        for (int i = 0; i < 4; i++) begin
            if (s_r.cnt >= bound(FR[i], 1000 - TOL_PM) &&
                s_r.cnt <= bound(FR[i], 1000 + TOL_PM)) begin
                m_ok = 1'b1;
                m_idx = 2'(i);
            end
        end
        if (s_r.cnt > bound(F0, 1000 + TOL_PM)) begin
            // no edges: tone gone, drop at once
            s_nxt.cnt = 24'h000000;
            s_nxt.nper = 4'h0;
            s_nxt.valid = 1'b0;
            s_nxt.prev_ok = 1'b0;
        end else if (rise) begin
            if (s_r.nper == LAST) begin
                // two agreeing averaged windows keep voice out
                s_nxt.valid = m_ok & s_r.prev_ok &
                    (m_idx == s_r.prev_idx);
                s_nxt.idx = m_idx;
                s_nxt.prev_ok = m_ok;
                s_nxt.prev_idx = m_idx;
                s_nxt.cnt = 24'h000000;
                s_nxt.nper = 4'h0;
            end else begin
                s_nxt.nper = s_r.nper + 4'h1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tone_valid = s_r.valid;
    assign tone_idx = s_r.idx;
endmodule : dtd_tone_meas
`default_nettype wire

// ==== src/dtd_receiver.sv ====
/*
 * digital side of a tone-pair receiver: two group measurers, early
 * steering, guard time, receive latch, status, and a strobe host port.
 * assumes comparator outputs and host strobes asynchronous to core_clk;
 * the steering level arrives as the output of an external threshold
 * comparator; the transmitter and analog parts live elsewhere.
 */
// Operation
// - tone inputs are full-rail comparator outputs
// - count frequencies, both must match standard tones
// - average measurements, reject voice imitations
// - early steering high on valid pair
// - early steering low at once on loss
// - steering rise registers the detected code
// - steering fall frees for a new pair
// - guard output follows early steering and steering
// - four low, four high tones, sixteen pairs
// - standard four-bit code per pair
// - interrupt mode pulls pin low on receipt
// - call-progress mode pin follows filtered input
// - data bus driven only during selected read
// - register select chooses the register reached
// - latch code, settle, then set delayed steering
// - status read clears valid bit and interrupt
// - call-progress mode stops tone-pair detection
`include "dtd_regs.svh"
`default_nettype none
module dtd_receiver
    import dtd_pkg::*;
#(
    parameter int CLK_HZ = `DTD_CLK_HZ,
    parameter int AVG_N = `DTD_AVG_PERIODS,
    parameter int TOL_PM = `DTD_TOL_PERMILLE
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic low_tone_in,
    input wire logic high_tone_in,
    input wire logic cp_tone_in,
    input wire logic steer_threshold,
    output logic guard_time_out,
    output logic guard_time_oe,
    output logic early_steer_out,
    output logic irq_or_tone_monitor_out,
    output logic irq_or_tone_monitor_oe,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic reg_select_bit,
    input wire logic [3:0] host_data_nibble_in,
    output logic [3:0] host_data_nibble_out,
    output logic host_data_nibble_oe
);
    localparam logic [3:0] SETTLE_CYC = 4'(`DTD_SETTLE_CYC);

    // row index picks the low tone, column index the high tone
    function automatic logic [3:0] pair_code(logic [1:0] r, logic [1:0] c);
        logic [3:0] k;
        k = 4'h0;
        case ({r, c})
            4'h0: k = 4'h1;
            4'h1: k = 4'h2;
            4'h2: k = 4'h3;
            4'h4: k = 4'h4;
            4'h5: k = 4'h5;
            4'h6: k = 4'h6;
            4'h8: k = 4'h7;
            4'h9: k = 4'h8;
            4'hA: k = 4'h9;
            4'hD: k = 4'hA;
            4'hC: k = 4'hB;
            4'hE: k = 4'hC;
            4'h3: k = 4'hD;
            4'h7: k = 4'hE;
            4'hB: k = 4'hF;
            default: k = 4'h0;
        endcase
        return k;
    endfunction : pair_code

    dtd_top_type s_r, s_nxt;
    logic low_ok, high_ok;
    logic [1:0] row_idx, col_idx;
    logic steer_s, cs_s, rd_s, wr_s, rs_s;
    logic [3:0] din_s;
    logic sig_cond, steer_rise, rd_end, wr_end, dstb_set;

    dtd_tone_meas #(
        .CLK_HZ(CLK_HZ), .AVG_N(AVG_N), .TOL_PM(TOL_PM),
        .F0(`DTD_F_LOW0), .F1(`DTD_F_LOW1),
        .F2(`DTD_F_LOW2), .F3(`DTD_F_LOW3)
    ) u_low (
        .core_clk(core_clk),
        .rst(rst),
        .tone_in(low_tone_in),
        .tone_valid(low_ok),
        .tone_idx(row_idx)
    );

    dtd_tone_meas #(
        .CLK_HZ(CLK_HZ), .AVG_N(AVG_N), .TOL_PM(TOL_PM),
        .F0(`DTD_F_HIGH0), .F1(`DTD_F_HIGH1),
        .F2(`DTD_F_HIGH2), .F3(`DTD_F_HIGH3)
    ) u_high (
        .core_clk(core_clk),
        .rst(rst),
        .tone_in(high_tone_in),
        .tone_valid(high_ok),
        .tone_idx(col_idx)
    );

    always_comb begin
        s_nxt = s_r;
        // first stages are only read by the second stages
        s_nxt.steer_sy = {s_r.steer_sy[0], steer_threshold};
        s_nxt.cp_sy = {s_r.cp_sy[0], cp_tone_in};
        s_nxt.cs_sy = {s_r.cs_sy[0], cs_n};
        s_nxt.rd_sy = {s_r.rd_sy[0], rd_n};
        s_nxt.wr_sy = {s_r.wr_sy[0], wr_n};
        s_nxt.rs_sy = {s_r.rs_sy[0], reg_select_bit};
        s_nxt.din_sy = {s_r.din_sy[3:0], host_data_nibble_in};
        steer_s = s_r.steer_sy[1];
        cs_s = s_r.cs_sy[1];
        rd_s = s_r.rd_sy[1];
        wr_s = s_r.wr_sy[1];
        rs_s = s_r.rs_sy[1];
        din_s = s_r.din_sy[7:4];
        s_nxt.steer_d = steer_s;
        s_nxt.rd_d = rd_s;
        s_nxt.wr_d = wr_s;
        steer_rise = steer_s & ~s_r.steer_d;
        rd_end = rd_s & ~s_r.rd_d;
        wr_end = wr_s & ~s_r.wr_d;
        dstb_set = 1'b0;

        sig_cond = low_ok & high_ok & ~s_r.cp_mode;
        s_nxt.early_steer = sig_cond;
        if (sig_cond) begin
            s_nxt.code = pair_code(row_idx, col_idx);
        end

        // guard holds between the two agreeing corners
        if (s_r.early_steer & steer_s) begin
            s_nxt.guard = 1'b1;
        end else if (~s_r.early_steer & ~steer_s) begin
            s_nxt.guard = 1'b0;
        end
        s_nxt.guard_oe = 1'b1;

        case (s_r.st)
            DTD_ST_IDLE: begin
                if (steer_rise & ~s_r.cp_mode) begin
                    s_nxt.rx_code = s_r.code;
                    s_nxt.settle = 4'h0;
                    s_nxt.st = DTD_ST_SETTLE;
                end
            end
            DTD_ST_SETTLE: begin
                s_nxt.settle = s_r.settle + 4'h1;
                if (s_r.settle >= SETTLE_CYC - 4'h1) begin
                    dstb_set = 1'b1;
                    s_nxt.delayed_steer = 1'b1;
                    s_nxt.st = DTD_ST_HELD;
                end
            end
            DTD_ST_HELD: begin
                if (~steer_s) begin
                    s_nxt.delayed_steer = 1'b0;
                    s_nxt.st = DTD_ST_IDLE;
                end
            end
            default: begin
                s_nxt.st = DTD_ST_IDLE;
            end
        endcase

        // a set in the clearing cycle survives the clear
        if (rd_end & s_r.stat_read) begin
            s_nxt.rx_valid = 1'b0;
            s_nxt.irq_pend = 1'b0;
        end
        if (dstb_set) begin
            s_nxt.rx_valid = 1'b1;
            s_nxt.irq_pend = 1'b1;
        end

        // status read marked while the strobe is low
        if (~cs_s & ~rd_s) begin
            s_nxt.stat_read = (rs_s == `DTD_SEL_STATUS);
        end else if (rd_end) begin
            s_nxt.stat_read = 1'b0;
        end

        // host must hold data past the write strobe's rising edge
        if (wr_end & ~cs_s & (rs_s == `DTD_SEL_STATUS)) begin
            s_nxt.irq_en = din_s[`DTD_CTRL_IRQEN_BIT];
            s_nxt.cp_mode = din_s[`DTD_CTRL_CPM_BIT];
        end

        s_nxt.dout_oe = ~cs_s & ~rd_s;
        s_nxt.dout = s_r.rx_code;
        if (rs_s == `DTD_SEL_STATUS) begin
            s_nxt.dout = 4'h0;
            s_nxt.dout[`DTD_STAT_IRQ_BIT] = s_r.irq_pend;
            s_nxt.dout[`DTD_STAT_RXV_BIT] = s_r.rx_valid;
        end

        s_nxt.irq_lvl = 1'b0;
        if (s_r.cp_mode) begin
            s_nxt.irq_oe = ~s_r.cp_sy[1];
        end else begin
            s_nxt.irq_oe = s_r.irq_en & s_r.irq_pend;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
            // strobes and select rest high: no false access after reset
            s_r.cs_sy <= '1;
            s_r.rd_sy <= '1;
            s_r.wr_sy <= '1;
            s_r.rd_d <= 1'b1;
            s_r.wr_d <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign early_steer_out = s_r.early_steer;
    assign guard_time_out = s_r.guard;
    assign guard_time_oe = s_r.guard_oe;
    assign irq_or_tone_monitor_out = s_r.irq_lvl;
    assign irq_or_tone_monitor_oe = s_r.irq_oe;
    assign host_data_nibble_out = s_r.dout;
    assign host_data_nibble_oe = s_r.dout_oe;
endmodule : dtd_receiver
`default_nettype wire

// ==== bench/dtd_receiver_props.sv ====
/* checker of the receiver pins: bus, guard, interrupt, early steering.
   assumes binding into dtd_receiver with its clock rate parameter. */
`default_nettype none
module dtd_receiver_props #(
    parameter int CLK_HZ = 125000
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic low_tone_in,
    input wire logic steer_threshold,
    input wire logic guard_time_out,
    input wire logic guard_time_oe,
    input wire logic early_steer_out,
    input wire logic irq_or_tone_monitor_out,
    input wire logic irq_or_tone_monitor_oe,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic reg_select_bit,
    input wire logic host_data_nibble_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    // stalled low tone: five periods covers window plus sync delay
    localparam int QLIM = 5 * CLK_HZ / 697 + 16;
    logic lo_r;
    int quiet_r;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lo_r <= 1'b0;
            quiet_r <= 0;
        end else begin
            lo_r <= low_tone_in;
            quiet_r <= (lo_r != low_tone_in) ? 0 : quiet_r + 1;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    sequence s_read_on;
        (!cs_n && !rd_n) [*5];
    endsequence
    sequence s_stat_read;
        (!cs_n && !rd_n && reg_select_bit) [*5] ##1 rd_n [*8];
    endsequence
    property p_bus_drive;
        s_read_on |-> host_data_nibble_oe;
    endproperty
    property p_bus_quiet;
        (cs_n || rd_n) [*5] |-> !host_data_nibble_oe;
    endproperty
    property p_stat_clear;
        s_stat_read |-> !irq_or_tone_monitor_oe;
    endproperty
    property p_guard_set;
        (early_steer_out && steer_threshold) [*5] |-> guard_time_out;
    endproperty
    property p_guard_clr;
        (!early_steer_out && !steer_threshold) [*5] |-> !guard_time_out;
    endproperty
    property p_gt_oe;
        !$past(rst) |-> guard_time_oe;
    endproperty
    property p_irq_level;
        irq_or_tone_monitor_oe |-> !irq_or_tone_monitor_out;
    endproperty
    property p_early_quiet;
        quiet_r > QLIM |-> !early_steer_out;
    endproperty
    a_bus_drive: assert property (p_bus_drive)
        else $error("data bus idle during read");
    a_bus_quiet: assert property (p_bus_quiet)
        else $error("data bus driven while not read");
    a_stat_clear: assert property (p_stat_clear)
        else $error("interrupt kept after status read");
    a_guard_set: assert property (p_guard_set)
        else $error("guard low with early and steering high");
    a_guard_clr: assert property (p_guard_clr)
        else $error("guard high with early and steering low");
    a_gt_oe: assert property (p_gt_oe)
        else $error("guard pin not driven");
    a_irq_level: assert property (p_irq_level)
        else $error("open drain pin driven high");
    a_early_quiet: assert property (p_early_quiet)
        else $error("early steering kept without low tone");
endmodule : dtd_receiver_props
bind dtd_receiver dtd_receiver_props #(.CLK_HZ(CLK_HZ)) dtd_receiver_props_inst (
    .core_clk(core_clk), .rst(rst), .low_tone_in(low_tone_in),
    .steer_threshold(steer_threshold), .guard_time_out(guard_time_out),
    .guard_time_oe(guard_time_oe), .early_steer_out(early_steer_out),
    .irq_or_tone_monitor_out(irq_or_tone_monitor_out),
    .irq_or_tone_monitor_oe(irq_or_tone_monitor_oe), .cs_n(cs_n),
    .rd_n(rd_n), .reg_select_bit(reg_select_bit),
    .host_data_nibble_oe(host_data_nibble_oe)
);
`default_nettype wire

// ==== bench/dtd_line_model.sv ====
/* line side: two limited tone groups and the steering rc network.
   assumes half periods in core_clk cycles, zero meaning silence. */
`default_nettype none
module dtd_line_model #(
    parameter int VMAX = 200,
    parameter int VTH = 150
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] lo_half,
    input wire logic [7:0] hi_half,
    input wire logic early_steer_out,
    input wire logic guard_time_out,
    output logic low_tone,
    output logic high_tone,
    output logic steer
);
    timeunit 1ns;
    timeprecision 1ns;
    int lo_c, hi_c, vc;
    assign steer = vc >= VTH;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lo_c <= 0;
            hi_c <= 0;
            vc <= 0;
            low_tone <= 1'b0;
            high_tone <= 1'b0;
        end else begin
            // full rail square waves, silent lines rest low
            lo_c <= (lo_c + 1 >= lo_half) ? 0 : lo_c + 1;
            hi_c <= (hi_c + 1 >= hi_half) ? 0 : hi_c + 1;
            if (lo_half == 8'h0) low_tone <= 1'b0;
            else if (lo_c + 1 >= lo_half) low_tone <= !low_tone;
            if (hi_half == 8'h0) high_tone <= 1'b0;
            else if (hi_c + 1 >= hi_half) high_tone <= !high_tone;
            // guard with early steering pulls the cap to full charge
            if (early_steer_out && guard_time_out) vc <= VMAX;
            else if (early_steer_out) vc <= (vc < VMAX) ? vc + 1 : VMAX;
            else vc <= (vc > 0) ? vc - 1 : 0;
        end
    end
endmodule : dtd_line_model
`default_nettype wire

// ==== bench/dtd_receiver_test.sv ====
/* self-checking bench of the receiver: pairs, steering, host port.
   assumes a scaled clock rate so a tone period is under 200 cycles. */
`default_nettype none
module dtd_receiver_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HZ = 125000;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic cs_n = 1'b1;
    logic rd_n = 1'b1;
    logic wr_n = 1'b1;
    logic rs = 1'b0;
    logic cp_tone = 1'b0;
    logic [3:0] din = 4'h0;
    logic [7:0] lo_half = 8'h0;
    logic [7:0] hi_half = 8'h0;
    logic lo_t, hi_t, steer, guard, guard_oe, early, irq_out, irq_oe, doe;
    logic [3:0] dout;
    int fails = 0;
    int comparisons = 0;
    // half periods: 697 770 852 941, then 1209 1336 1477 1633
    logic [7:0] lo_tab [4] = '{8'h5A, 8'h51, 8'h49, 8'h42};
    logic [7:0] hi_tab [4] = '{8'h34, 8'h2F, 8'h2A, 8'h26};
    initial forever #4 core_clk = ~core_clk;
    dtd_receiver #(.CLK_HZ(HZ)) dtd_receiver_inst (
        .core_clk(core_clk), .rst(rst), .low_tone_in(lo_t),
        .high_tone_in(hi_t), .cp_tone_in(cp_tone),
        .steer_threshold(steer), .guard_time_out(guard),
        .guard_time_oe(guard_oe), .early_steer_out(early),
        .irq_or_tone_monitor_out(irq_out),
        .irq_or_tone_monitor_oe(irq_oe), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .reg_select_bit(rs), .host_data_nibble_in(din),
        .host_data_nibble_out(dout), .host_data_nibble_oe(doe)
    );
    dtd_line_model dtd_line_model_inst (
        .core_clk(core_clk), .rst(rst), .lo_half(lo_half),
        .hi_half(hi_half), .early_steer_out(early),
        .guard_time_out(guard), .low_tone(lo_t), .high_tone(hi_t),
        .steer(steer)
    );
    function automatic logic [3:0] code_of(input int r, input int c);
        if (c == 3) return (r == 3) ? 4'h0 : 4'(r) + 4'hD;
        if (r == 3) return (c == 0) ? 4'hB : (c == 1) ? 4'hA : 4'hC;
        return 4'(r * 3 + c + 1);
    endfunction : code_of
    task automatic check(input string what, input logic [3:0] exp,
                         input logic [3:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // strobe first, select later: write is taken on the strobe rise
    task automatic access(input logic rd, input logic sel,
                          input logic [3:0] d, output logic [3:0] q);
        cs_n <= 1'b0;
        rd_n <= !rd;
        wr_n <= rd;
        rs <= sel;
        din <= d;
        repeat (6) @(posedge core_clk);
        q = dout;
        if (rd) check("read enable", 4'h1, {3'h0, doe});
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        cs_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        check("bus release", 4'h0, {3'h0, doe});
    endtask : access
    task automatic wait_for(ref logic sig, input logic lvl,
                            input string what);
        int n;
        n = 0;
        while (sig !== lvl && n < 4000) begin
            @(posedge core_clk);
            n++;
        end
        check(what, {3'h0, lvl}, {3'h0, sig});
    endtask : wait_for
    task automatic summarize();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize
    initial begin
        logic [3:0] q;
        repeat (2) @(posedge core_clk);
        check("reset outputs", 4'h0, {doe, early, irq_oe, guard});
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        check("guard enable", 4'h1, {3'h0, guard_oe});
        check("bus after reset", 4'h0, {3'h0, doe});
        access(1'b0, 1'b1, 4'h1, q);
        // data register write must leave control alone
        access(1'b0, 1'b0, 4'h2, q);
        for (int i = 0; i < 16; i++) begin
            lo_half <= lo_tab[i / 4];
            hi_half <= hi_tab[i % 4];
            wait_for(early, 1'b1, "early");
            wait_for(irq_oe, 1'b1, "interrupt");
            access(1'b1, 1'b1, 4'h0, q);
            check("status", 4'h5, q);
            access(1'b1, 1'b1, 4'h0, q);
            check("status cleared", 4'h0, q);
            check("irq cleared", 4'h0, {3'h0, irq_oe});
            access(1'b1, 1'b0, 4'h0, q);
            check("code", code_of(i / 4, i % 4), q);
            lo_half <= 8'h0;
            hi_half <= 8'h0;
            wait_for(early, 1'b0, "early drop");
            wait_for(steer, 1'b0, "steer free");
        end
        // valid low tone, high tone 6 percent above the top one
        lo_half <= lo_tab[0];
        hi_half <= 8'h24;
        repeat (3000) @(posedge core_clk);
        check("off tone", 4'h0, {3'h0, early});
        access(1'b0, 1'b1, 4'h3, q);
        hi_half <= hi_tab[0];
        repeat (3000) @(posedge core_clk);
        check("cp no pair", 4'h0, {3'h0, early});
        cp_tone <= 1'b1;
        repeat (5) @(posedge core_clk);
        check("cp high", 4'h0, {3'h0, irq_oe});
        cp_tone <= 1'b0;
        repeat (5) @(posedge core_clk);
        check("cp low", 4'h1, {3'h0, irq_oe});
        summarize();
    end
    initial begin
        repeat (90000) @(posedge core_clk);
        fails++;
        $display("ERROR watchdog expected end seen timeout");
        summarize();
    end
endmodule : dtd_receiver_test
`default_nettype wire
